// ===== bench/ffd_decoder_properties.sv
// Checker of the decoder's port behaviour
`timescale 1ns/1ps
module ffd_chk (
    input wire logic              clock_i,
    input wire logic              resetn_i,
    input wire logic              in_valid_i,
    input wire ffd_pkg::ffd_fmt_t in_format_i,
    input wire logic [63:0]       in_word_i,
    input wire ffd_pkg::ffd_dec_t out_dec_o,
    input wire ffd_pkg::ffd_rgb_t out_rgb_o,
    input wire logic [15:0]       out_half_o
);
    import ffd_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    wire       v32 = in_valid_i && in_format_i == FMT_F32;
    wire [7:0] e32 = in_word_i[30:23];
    wire [10:0] e64 = in_word_i[62:52];
    f64_exp_a: assert property (
        in_valid_i && in_format_i == FMT_F64 && |e64 && !(&e64) |=>
        out_dec_o.exp + 12'h3ff == {1'b0, $past(e64)} && out_dec_o.sig[52])
        else $error("f64 exponent");
    f64_nan_a: assert property (
        in_valid_i && in_format_i == FMT_F64 && &e64 && |in_word_i[51:0]
        |=> out_dec_o.cls == CLS_NAN) else $error("f64 nan");
    f32_inf_a: assert property (
        v32 && e32 == 8'hff && in_word_i[22:0] == 23'h0 |=>
        out_dec_o.cls == CLS_INF && out_dec_o.sign == $past(in_word_i[31]))
        else $error("f32 infinity");
    f16_zero_a: assert property (
        in_valid_i && in_format_i == FMT_F16 && in_word_i[14:0] == 15'h0
        |=> out_dec_o.cls == CLS_ZERO && out_dec_o.sign == $past(in_word_i[15]))
        else $error("f16 zero");
    small_unsigned_a: assert property (
        in_valid_i && (in_format_i == FMT_U11 || in_format_i == FMT_U10)
        |=> !out_dec_o.sign) else $error("small sign");
    shared_exp_a: assert property (
        in_valid_i && in_format_i == FMT_SHX |=>
        out_rgb_o.exp + 6'h0f == {1'b0, $past(in_word_i[31:27])})
        else $error("shared exponent");
    narrow_ovf_a: assert property (
        v32 && e32 >= 8'h8f && e32 != 8'hff |=>
        out_half_o == {$past(in_word_i[31]), 15'h7c00})
        else $error("narrow overflow");
    narrow_nan_a: assert property (
        v32 && e32 == 8'hff && |in_word_i[22:0] |=> out_half_o[14:10] == 5'h1f
        && |out_half_o[9:0] && out_half_o[15] == $past(in_word_i[31]))
        else $error("narrow nan");
endmodule
bind ffd_decoder ffd_chk ffd_chk_i (.clock_i, .resetn_i, .in_valid_i,
    .in_format_i, .in_word_i, .out_dec_o, .out_rgb_o, .out_half_o);

// ===== bench/tb.sv
// Self-checking bench of the format decoder
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import ffd_pkg::*;
    logic        clock_i     = 1'b0;
    logic        resetn_i    = 1'b0;
    logic        in_valid_i  = 1'b0;
    ffd_fmt_t    in_format_i = FMT_F64;
    logic [63:0] in_word_i   = 64'h0;
    logic        out_valid_o;
    ffd_fmt_t    out_format_o;
    ffd_dec_t    out_dec_o;
    ffd_rgb_t    out_rgb_o;
    logic [15:0] out_half_o;
    ffd_fmt_t    fm;
    int          bad_count   = 0;
    int          tests_run   = 0;
    always #2.5 clock_i = ~clock_i;
    ffd_decoder ffd_decoder_i (.clock_i, .resetn_i, .in_valid_i,
        .in_format_i, .in_word_i, .out_valid_o, .out_format_o,
        .out_dec_o, .out_rgb_o, .out_half_o);
    task automatic put(ffd_fmt_t f, logic [63:0] w);
        @(posedge clock_i);
        in_valid_i <= 1'b1;
        in_format_i <= f;
        in_word_i <= w;
        @(posedge clock_i);
        in_valid_i <= 1'b0;
        @(negedge clock_i);
        `CHK(out_valid_o, 1'b1)
    endtask
    task automatic dec(logic [63:0] w, ffd_cls_t c, logic [11:0] e,
                       logic [52:0] g);
        logic s;
        s = fm == FMT_F64 ? w[63] : fm == FMT_F32 ? w[31] :
            fm == FMT_F16 ? w[15] : 1'b0;
        put(fm, w);
        `CHK(out_format_o, fm)
        `CHK(out_dec_o.cls, c)
        `CHK(out_dec_o.sign, s)
        `CHK(out_dec_o.exp, e)
        if (c != CLS_NAN) `CHK(out_dec_o.sig, g)
    endtask
    task automatic half(logic [31:0] w, logic [15:0] h);
        put(FMT_F32, {32'h0, w});
        `CHK(out_half_o, h)
    endtask
    task automatic t_f64;
        fm = FMT_F64;
        dec(64'h3ff8 << 48, CLS_NORMAL, 12'h0, 53'd3 << 51);
        dec(64'hfff << 52, CLS_INF, 12'h0, 53'h0);
        dec({1'b1, 63'h1}, CLS_DENORM, 12'hc02, 53'h1);
    endtask
    task automatic t_f32;
        fm = FMT_F32;
        dec(64'hc1200000, CLS_NORMAL, 12'h003, 53'd5 << 50);
        dec(64'hff800001, CLS_NAN, 12'h0, 53'h0);
        dec(64'h1, CLS_DENORM, 12'hf82, 53'd1 << 29);
        dec(64'h80000000, CLS_ZERO, 12'h0, 53'h0);
    endtask
    task automatic t_f16;
        fm = FMT_F16;
        dec(64'h7bff, CLS_NORMAL, 12'h00f, 53'h7ff << 42);
        dec(64'hfc00, CLS_INF, 12'h0, 53'h0);
        dec(64'h1, CLS_DENORM, 12'hff2, 53'd1 << 42);
    endtask
    task automatic t_small;
        fm = FMT_U11;
        dec(64'h7c0, CLS_INF, 12'h0, 53'h0);
        dec(64'h7c1, CLS_NAN, 12'h0, 53'h0);
        dec(64'h1, CLS_DENORM, 12'hff2, 53'd1 << 46);
        fm = FMT_U10;
        dec(64'h3df, CLS_NORMAL, 12'h00f, 53'h3f << 47);
        dec(64'h1, CLS_DENORM, 12'hff2, 53'd1 << 47);
    endtask
    task automatic t_shx;
        put(FMT_SHX, 64'h87fc0101);
        `CHK(out_rgb_o, {6'h01, 3'b010, 9'h1ff, 9'h0, 9'h101})
        `CHK(out_dec_o.cls, CLS_ZERO)
        put(FMT_SHX, 64'h0);
        `CHK(out_rgb_o, {6'h31, 3'b111, 27'h0})
    endtask
    task automatic t_narrow;
        half(32'h3f801000, 16'h3c00);
        half(32'h3f803000, 16'h3c02);
        half(32'h3f801001, 16'h3c01);
        half(32'h477ff000, 16'h7c00);
        half(32'h38800000, 16'h0400);
        half(32'h38000000, 16'h0200);
        half(32'h33000000, 16'h0000);
        half(32'h387fe000, 16'h0400);
        half(32'hffc00000, 16'hff00);
    endtask
    task automatic results;
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        t_f64();
        t_f32();
        t_f16();
        t_small();
        t_shx();
        t_narrow();
        results();
    end
    initial begin
        #100000;
        bad_count++;
        results();
    end
endmodule

// ===== verilog/ffd_decoder.sv
// One-stage decoder of the stored floating-point formats and 32-to-16 narrowing
`timescale 1ns/1ps
module ffd_decoder (
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    input  wire logic              in_valid_i,
    input  wire ffd_pkg::ffd_fmt_t in_format_i,
    input  wire logic [63:0]       in_word_i,
    output logic                   out_valid_o,
    output ffd_pkg::ffd_fmt_t      out_format_o,
    output ffd_pkg::ffd_dec_t      out_dec_o,
    output ffd_pkg::ffd_rgb_t      out_rgb_o,
    output logic [15:0]            out_half_o
);
    import ffd_pkg::*;

    // Generic classifier; fraction arrives left aligned in 52 bits
    function automatic ffd_dec_t classify(
        input logic        s,
        input logic [10:0] e,
        input logic [10:0] emax,
        input logic [51:0] f,
        input logic [11:0] bias
    );
        ffd_dec_t d;
        d.sign = s;
        d.exp  = 12'sh000;
        d.sig  = {1'b0, f};
        if (e == emax) begin
            d.cls = (f != 52'h0) ? CLS_NAN : CLS_INF;
        end else if (e != 11'h000) begin
            d.cls = CLS_NORMAL;
            d.exp = $signed({1'b0, e} - bias);
            d.sig = {1'b1, f};
        end else if (f != 52'h0) begin
            d.cls = CLS_DENORM;
            d.exp = $signed(12'h001 - bias);
        end else begin
            d.cls = CLS_ZERO;
        end
        return d;
    endfunction

    ffd_dec_t   next_dec;
    ffd_rgb_t   next_rgb;
    logic [15:0] next_half;

    // Format decode
    always_comb begin
        next_dec = DEC_RESET;
        case (in_format_i)
            FMT_F64: begin
                next_dec = classify(in_word_i[F64_SIGN],
                    in_word_i[F64_EXP_HI:F64_EXP_LO], F64_EXP_MAX,
                    in_word_i[F64_FRAC_W-1:0], F64_BIAS);
            end
            FMT_F32: begin
                next_dec = classify(in_word_i[F32_SIGN],
                    {3'b000, in_word_i[F32_EXP_HI:F32_EXP_LO]}, F32_EXP_MAX,
                    {in_word_i[F32_FRAC_W-1:0], 29'h0},
                    F32_BIAS);
            end
            FMT_F16: begin
                next_dec = classify(in_word_i[F16_SIGN],
                    {6'h00, in_word_i[F16_EXP_HI:F16_EXP_LO]}, F16_EXP_MAX,
                    {in_word_i[F16_FRAC_W-1:0], 42'h0},
                    F16_BIAS);
            end
            FMT_U11: begin
                next_dec = classify(1'b0,
                    {6'h00, in_word_i[U11_EXP_HI:U11_EXP_LO]}, F16_EXP_MAX,
                    {in_word_i[U11_FRAC_W-1:0], 46'h0},
                    F16_BIAS);
            end
            FMT_U10: begin
                next_dec = classify(1'b0,
                    {6'h00, in_word_i[U10_EXP_HI:U10_EXP_LO]}, F16_EXP_MAX,
                    {in_word_i[U10_FRAC_W-1:0], 47'h0},
                    F16_BIAS);
            end
            FMT_SHX: begin
                next_dec.cls = CLS_ZERO;
            end
            default: begin
                next_dec = DEC_RESET;
            end
        endcase
    end

    // Shared-exponent channels, each 0.f scaled by 2^(e-15)
    logic [SHX_FRAC_W-1:0] shx_frac [SHX_CHANNELS];
    logic [SHX_CHANNELS-1:0] shx_zero;

    genvar ch;
    generate
        for (ch = 0; ch < SHX_CHANNELS; ch++) begin : g_shx
            assign shx_frac[ch] =
                in_word_i[ch*SHX_FRAC_W +: SHX_FRAC_W];
            assign shx_zero[ch] =
                (shx_frac[ch] == '0);
        end
    endgenerate

    always_comb begin
        next_rgb       = RGB_RESET;
        next_rgb.exp   = $signed({1'b0, in_word_i[SHX_EXP_HI:SHX_EXP_LO]})
                       - 6'sd15;
        next_rgb.zero  = shx_zero;
        next_rgb.red   = shx_frac[0];
        next_rgb.green = shx_frac[1];
        next_rgb.blue  = shx_frac[2];
    end

    // Narrowing of the low 32 bits to the 16-bit format
    logic        nar_s;
    logic [7:0]  nar_e;
    logic [22:0] nar_f;
    logic [7:0]  nar_sh;
    logic [47:0] nar_ext;
    logic [14:0] nar_base;
    logic        nar_guard;
    logic        nar_sticky;
    logic        nar_up;
    logic [14:0] nar_mag;

    assign nar_s = in_word_i[F32_SIGN];
    assign nar_e = in_word_i[F32_EXP_HI:F32_EXP_LO];
    assign nar_f = in_word_i[F32_FRAC_W-1:0];

    always_comb begin
        nar_sh = NAR_DEN_BASE - nar_e;
        if (nar_sh > NAR_SHIFT_CAP) begin
            nar_sh = NAR_SHIFT_CAP;
        end
        nar_ext = {(nar_e != 8'h00), nar_f, 24'h0} >> nar_sh;
    end

    always_comb begin
        if (nar_e >= NAR_MIN_EXP) begin
            nar_base   = {5'(nar_e - NAR_EXP_OFS), nar_f[22:13]};
            nar_guard  = nar_f[12];
            nar_sticky = |nar_f[11:0];
        end else begin
            nar_base   = {5'h00, nar_ext[33:24]};
            nar_guard  = nar_ext[23];
            nar_sticky = |nar_ext[22:0];
        end
        nar_up  = nar_guard & (nar_sticky | nar_base[0]);
        nar_mag = nar_base + {14'h0, nar_up};
    end

    always_comb begin
        if (nar_e == F32_EXP_MAX[7:0] && nar_f != 23'h0) begin
            next_half = {nar_s, F16_EXP_MAX[4:0], 1'b1,
                         nar_f[22:14]};
        end else if (nar_e >= NAR_INF_EXP) begin
            next_half = {nar_s, F16_EXP_MAX[4:0], 10'h000};
        end else begin
            next_half = {nar_s, nar_mag};
        end
    end

    // Output registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_o  <= 1'b0;
            out_format_o <= FMT_F64;
        end else begin
            out_valid_o  <= in_valid_i;
            out_format_o <= in_format_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_dec_o <= DEC_RESET;
        end else if (in_valid_i) begin
            out_dec_o <= next_dec;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_rgb_o <= RGB_RESET;
        end else if (in_valid_i && in_format_i == FMT_SHX) begin
            out_rgb_o <= next_rgb;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_half_o <= 16'h0000;
        end else if (in_valid_i && in_format_i == FMT_F32) begin
            out_half_o <= next_half;
        end
    end

endmodule

// ===== verilog/ffd_pkg.sv
// Package for the floating-point format decoder: layouts, classes, types
// Notes on behaviour
// - 64-bit: sign 63, exponent 62:52, fraction 51:0; normal is 2^(e-1023)*1.f
// - 64-bit: all-ones exponent is NaN or signed infinity; zero exponent denormal/zero
// - 32-bit: sign 31, exponent 30:23, fraction 22:0; normal is 2^(e-127)*1.f
// - 32-bit: exponent 255 NaN or infinity; exponent 0 gives 2^-126*0.f or zero
// - 16-bit: exponent 31 NaN or infinity; exponent 0 gives 2^-14*0.f or zero
// - Narrowing 32-bit to 16-bit rounds to nearest, ties to even
// - Narrowing: exponent 143 up gives infinity, except 255 with nonzero fraction gives NaN; 113 gives 1, below denormal
// - Unsigned 11-bit: exponent 10:6, fraction 5:0, no sign
// - Unsigned 10-bit: exponent 9:5, fraction 4:0, no sign
// - Unsigned small: 31 NaN or +infinity, normal 2^(e-15)*1.f, 0 denormal
// - Shared word: exponent 31:27, blue 26:18, green 17:9, red 8:0
// - Shared channels are 0.f*2^(e-15); only zero and positive values
package ffd_pkg;

    localparam int F64_SIGN = 63;
    localparam int F64_EXP_HI = 62;
    localparam int F64_EXP_LO = 52;
    localparam int F64_FRAC_W = 52;
    localparam logic [11:0] F64_BIAS = 12'h3ff;
    localparam logic [10:0] F64_EXP_MAX = 11'h7ff;

    localparam int F32_SIGN = 31;
    localparam int F32_EXP_HI = 30;
    localparam int F32_EXP_LO = 23;
    localparam int F32_FRAC_W = 23;
    localparam logic [11:0] F32_BIAS = 12'h07f;
    localparam logic [10:0] F32_EXP_MAX = 11'h0ff;

    localparam int F16_SIGN = 15;
    localparam int F16_EXP_HI = 14;
    localparam int F16_EXP_LO = 10;
    localparam int F16_FRAC_W = 10;
    localparam logic [11:0] F16_BIAS = 12'h00f;
    localparam logic [10:0] F16_EXP_MAX = 11'h01f;

    localparam int U11_EXP_HI = 10;
    localparam int U11_EXP_LO = 6;
    localparam int U11_FRAC_W = 6;
    localparam int U10_EXP_HI = 9;
    localparam int U10_EXP_LO = 5;
    localparam int U10_FRAC_W = 5;

    localparam int SHX_EXP_HI = 31;
    localparam int SHX_EXP_LO = 27;
    localparam int SHX_FRAC_W = 9;
    localparam int SHX_CHANNELS = 3;

    localparam logic [7:0] NAR_INF_EXP = 8'h8f;
    localparam logic [7:0] NAR_MIN_EXP = 8'h71;
    localparam logic [7:0] NAR_EXP_OFS = 8'h70;
    localparam logic [7:0] NAR_DEN_BASE = 8'h7e;
    localparam logic [7:0] NAR_SHIFT_CAP = 8'h19;

    typedef enum logic [2:0] {
        FMT_F64 = 3'b000,
        FMT_F32 = 3'b001,
        FMT_F16 = 3'b010,
        FMT_U11 = 3'b011,
        FMT_U10 = 3'b100,
        FMT_SHX = 3'b101
    } ffd_fmt_t;

    typedef enum logic [2:0] {
        CLS_ZERO   = 3'b000,
        CLS_DENORM = 3'b001,
        CLS_NORMAL = 3'b010,
        CLS_INF    = 3'b011,
        CLS_NAN    = 3'b100
    } ffd_cls_t;

    typedef struct packed {
        ffd_cls_t           cls;
        logic               sign;
        logic signed [11:0] exp;
        logic [52:0]        sig;
    } ffd_dec_t;

    typedef struct packed {
        logic signed [5:0] exp;
        logic [2:0]        zero;
        logic [8:0]        blue;
        logic [8:0]        green;
        logic [8:0]        red;
    } ffd_rgb_t;

    localparam ffd_dec_t DEC_RESET = '0;
    localparam ffd_rgb_t RGB_RESET = '0;

endpackage
